// ===== src/mies_pkg.sv
/*
 * Package for the instruction execution subset: opcodes, field
 * positions, register offsets and reset values.
 * Assumes a single 25 MHz core clock and an APB register port.
 */
package mies_pkg;
    // ==========================================================
    // Operation codes written by software into the command register
    typedef enum logic [3:0] {
        MIES_OP_NONE = 4'h0,
        MIES_OP_WDT_CLEAR = 4'h1,
        MIES_OP_DEC_ADJUST = 4'h2,
        MIES_OP_CPL_ACC = 4'h3,
        MIES_OP_DEC_ACC = 4'h4,
        MIES_OP_HALT = 4'h5,
        MIES_OP_RLC = 4'h6,
        MIES_OP_RRC = 4'h7,
        MIES_OP_RLCA = 4'h8,
        MIES_OP_RRCA = 4'h9,
        MIES_OP_MOV_A_M = 4'hA,
        MIES_OP_MOV_M_A = 4'hB,
        MIES_OP_OR_A_M = 4'hC,
        MIES_OP_ORM = 4'hD,
        MIES_OP_JMP = 4'hE,
        MIES_OP_RET = 4'hF
    } mies_op_t;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] MIES_REG_CMD = 8'h00;
    localparam logic [7:0] MIES_REG_ACC = 8'h04;
    localparam logic [7:0] MIES_REG_MEM = 8'h08;
    localparam logic [7:0] MIES_REG_FLAGS = 8'h0C;
    localparam logic [7:0] MIES_REG_PC = 8'h10;
    localparam logic [7:0] MIES_REG_WDT = 8'h14;

    // Flag register bit positions
    localparam int MIES_F_C = 0;
    localparam int MIES_F_AC = 1;
    localparam int MIES_F_Z = 2;
    localparam int MIES_F_OV = 3;
    localparam int MIES_F_PDF = 4;
    localparam int MIES_F_TO = 5;

    // Field widths and reset values
    localparam int MIES_PC_W = 12;
    localparam int MIES_WDT_W = 16;
    localparam logic [7:0] MIES_ACC_RST = 8'h00;
    localparam logic [5:0] MIES_FLAGS_RST = 6'h00;
    localparam logic [MIES_PC_W-1:0] MIES_PC_RST = 12'h000;
    localparam logic [3:0] MIES_BCD_MAX = 4'h9;
    localparam logic [3:0] MIES_BCD_FIX = 4'h6;
endpackage

// ===== src/mies_alu.sv
/*
 * Combinational execution unit for the instruction subset.
 * Assumes the caller registers every result and flag it uses.
 */
`timescale 1ns/1ns
module mies_alu
(
    // Operation and operands
    input wire mies_pkg::mies_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic carry_in,
    input wire logic aux_carry_flag,
    // Results
    output logic [7:0] result,
    output logic carry_out
);
    import mies_pkg::*;

    // ==========================================================
    // Decimal adjust per nibble
    logic nibble_carry;
    logic [3:0] lo_fix;
    logic [4:0] hi_sum;
    logic [3:0] hi_fix;
    logic hi_carry;

    // Low nibble is corrected first and hands its carry upward
    always_comb
    begin
        if (acc[3:0] > MIES_BCD_MAX || aux_carry_flag)
        begin
            {nibble_carry, lo_fix} = {1'b0, acc[3:0]} + {1'b0, MIES_BCD_FIX};
        end
        else
        begin
            nibble_carry = 1'b0;
            lo_fix = acc[3:0];
        end
        hi_sum = {1'b0, acc[7:4]} + {4'h0, nibble_carry};
        if (hi_sum > {1'b0, MIES_BCD_MAX} || carry_in)
        begin
            hi_fix = hi_sum[3:0] + MIES_BCD_FIX;
            hi_carry = 1'b1;
        end
        else
        begin
            hi_fix = hi_sum[3:0];
            hi_carry = 1'b0;
        end
    end

    // Result selection; carry passes through unless the op moves it
    always_comb
    begin
        result = acc;
        carry_out = carry_in;
        case (op)
            MIES_OP_DEC_ADJUST:
            begin
                result = {hi_fix, lo_fix};
                carry_out = hi_carry;
            end
            MIES_OP_CPL_ACC: result = ~mem;
            MIES_OP_DEC_ACC: result = mem - 8'h01;
            MIES_OP_RLC, MIES_OP_RLCA:
            begin
                result = {mem[6:0], carry_in};
                carry_out = mem[7];
            end
            MIES_OP_RRC, MIES_OP_RRCA:
            begin
                result = {carry_in, mem[7:1]};
                carry_out = mem[0];
            end
            MIES_OP_MOV_A_M: result = mem;
            MIES_OP_MOV_M_A: result = acc;
            MIES_OP_OR_A_M, MIES_OP_ORM: result = acc | mem;
            default: result = acc;
        endcase
    end
endmodule

// ===== src/mies_core.sv
/*
 * Execution core for a subset of an 8-bit controller instruction set,
 * with accumulator, one data memory byte, flags, program counter,
 * a one-deep return stack and watchdog count, all reached over APB.
 * Assumes one 25 MHz clock and an APB master with 32-bit data.
 */
// What this block does
// - Decimal adjust corrects both accumulator nibbles into packed BCD
// - Low nibble above nine or aux carry set adds six, else unchanged
// - High nibble plus carry above nine or carry set adds six, sets carry
// - Decimal adjust writes memory and alters only the carry flag
// - Complement puts the inverted memory byte in accumulator, memory unchanged
// - Decrement puts memory minus one in accumulator, memory unchanged
`timescale 1ns/1ns
module mies_core
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Watchdog timeout event and oscillator control
    input wire logic wdt_timeout,
    output logic osc_stop
);
    import mies_pkg::*;

    // ==========================================================
    // Architectural state
    logic [7:0] acc;
    logic [7:0] mem;
    logic [5:0] flags;
    logic [MIES_PC_W-1:0] pc;
    logic [MIES_PC_W-1:0] ret_stack;
    logic [MIES_WDT_W-1:0] wdt_count;
    logic timeout_sync1;
    logic timeout_sync2;
    logic [7:0] alu_result;
    logic alu_carry;
    logic wr;
    logic exec;
    mies_op_t op;

    // Single-cycle access keeps the master simple; no wait states
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign exec = wr && paddr == MIES_REG_CMD;
    assign op = mies_op_t'(pwdata[3:0]);

    // Unmapped addresses answer with an error
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = a == MIES_REG_CMD || a == MIES_REG_ACC || a == MIES_REG_MEM
            || a == MIES_REG_FLAGS || a == MIES_REG_PC || a == MIES_REG_WDT;
    endfunction

    assign pslverr = psel & penable & ~addr_ok(paddr);

    mies_alu u_alu
    (
        .op(op),
        .acc(acc),
        .mem(mem),
        .carry_in(flags[MIES_F_C]),
        .aux_carry_flag(flags[MIES_F_AC]),
        .result(alu_result),
        .carry_out(alu_carry)
    );

    // ==========================================================
    // Timeout input comes from the watchdog domain; resynchronise
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timeout_sync1 <= 1'b0;
            timeout_sync2 <= 1'b0;
        end
        else
        begin
            timeout_sync1 <= wdt_timeout;
            timeout_sync2 <= timeout_sync1;
        end
    end

    // Accumulator: loaded by software or by accumulator-target ops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc <= MIES_ACC_RST;
        else if (wr && paddr == MIES_REG_ACC)
            acc <= pwdata[7:0];
        else if (exec)
        begin
            case (op)
                MIES_OP_CPL_ACC, MIES_OP_DEC_ACC, MIES_OP_RLCA, MIES_OP_RRCA,
                MIES_OP_MOV_A_M, MIES_OP_OR_A_M:
                    acc <= alu_result;
                default: acc <= acc;
            endcase
        end
    end

    // Data memory byte: accumulator-target ops leave it untouched
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mem <= MIES_ACC_RST;
        else if (wr && paddr == MIES_REG_MEM)
            mem <= pwdata[7:0];
        else if (exec)
        begin
            case (op)
                MIES_OP_DEC_ADJUST, MIES_OP_RLC, MIES_OP_RRC, MIES_OP_MOV_M_A,
                MIES_OP_ORM:
                    mem <= alu_result;
                default: mem <= mem;
            endcase
        end
    end

    // Flags; a timeout arriving with a clear still sets the flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= MIES_FLAGS_RST;
        else if (wr && paddr == MIES_REG_FLAGS)
            flags <= pwdata[5:0] | {timeout_sync2, 5'h00};
        else if (exec)
        begin
            case (op)
                MIES_OP_WDT_CLEAR:
                begin
                    flags[MIES_F_TO] <= timeout_sync2;
                    flags[MIES_F_PDF] <= 1'b0;
                end
                MIES_OP_HALT:
                begin
                    flags[MIES_F_TO] <= timeout_sync2;
                    flags[MIES_F_PDF] <= 1'b1;
                end
                MIES_OP_DEC_ADJUST, MIES_OP_RLC, MIES_OP_RRC, MIES_OP_RLCA,
                MIES_OP_RRCA:
                    flags[MIES_F_C] <= alu_carry;
                MIES_OP_OR_A_M, MIES_OP_ORM:
                    flags[MIES_F_Z] <= alu_result == 8'h00;
                default:
                    flags[MIES_F_TO] <= flags[MIES_F_TO] | timeout_sync2;
            endcase
            // A timeout event during any op still sets the flag; set beats clear
            if (timeout_sync2)
                flags[MIES_F_TO] <= 1'b1;
        end
        else if (timeout_sync2)
            flags[MIES_F_TO] <= 1'b1;
    end

    // Watchdog count runs while the oscillator is not stopped and is zeroed by the clear op
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wdt_count <= '0;
        else if (exec && op == MIES_OP_WDT_CLEAR)
            wdt_count <= '0;
        else if (!osc_stop)
            wdt_count <= wdt_count + 1'b1;
    end

    // Halt stops the oscillator until reset or the next command write other than halt
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            osc_stop <= 1'b0;
        else if (exec && op == MIES_OP_HALT)
            osc_stop <= 1'b1;
        else if (exec)
            osc_stop <= 1'b0;
    end

    // Program counter: jump loads target, return pops the stack
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc <= MIES_PC_RST;
            ret_stack <= MIES_PC_RST;
        end
        else if (wr && paddr == MIES_REG_PC)
            ret_stack <= pwdata[MIES_PC_W-1:0];
        else if (exec && op == MIES_OP_JMP)
            pc <= pwdata[MIES_PC_W+3:4];
        else if (exec && op == MIES_OP_RET)
            pc <= ret_stack;
        else if (exec && op != MIES_OP_HALT)
            pc <= pc + 1'b1;
    end

    // Read data, registered from the setup phase
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == MIES_REG_ACC)
                prdata <= {24'h000000, acc};
            else if (paddr == MIES_REG_MEM)
                prdata <= {24'h000000, mem};
            else if (paddr == MIES_REG_FLAGS)
                prdata <= {26'h0000000, flags};
            else if (paddr == MIES_REG_PC)
                prdata <= {20'h00000, pc};
            else if (paddr == MIES_REG_WDT)
                prdata <= {16'h0000, wdt_count};
            else
                prdata <= '0;
        end
    end
endmodule

// ===== verification/mies_checker.sv
/* Port checker for mies_core: APB answers and oscillator stop.
   Sees only the core ports; bound by the statement at the foot. */
`timescale 1ns/1ns
module mies_checker
(
    // Clock, reset, APB and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_timeout,
    input wire logic osc_stop
);
    import mies_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Command writes; bench transfers complete three edges apart
    logic cmd_wr;
    assign cmd_wr = psel && penable && pwrite && paddr == MIES_REG_CMD;
    sequence s_halt;
        cmd_wr && pwdata[3:0] == MIES_OP_HALT;
    endsequence
    sequence s_wclr;
        cmd_wr && pwdata[3:0] == MIES_OP_WDT_CLEAR;
    endsequence
    sequence s_flag_rd;
        psel && penable && !pwrite && paddr == MIES_REG_FLAGS;
    endsequence
    // ==========================================================
    // Assertions
    chk_halt_stop: assert property (s_halt |=> osc_stop)
        else $error("oscillator not stopped after halt");
    chk_halt_pdf: assert property (s_halt ##3 s_flag_rd |-> prdata[4])
        else $error("power-down flag not set by halt");
    chk_clr_pdf: assert property (s_wclr ##3 s_flag_rd |-> !prdata[4])
        else $error("power-down flag not cleared by watchdog clear");
    chk_stop_hold: assert property (osc_stop && !cmd_wr |=> osc_stop)
        else $error("oscillator restarted without a command");
    chk_stop_end: assert property (cmd_wr && pwdata[3:0] != MIES_OP_HALT |=> !osc_stop)
        else $error("oscillator still stopped after command");
    chk_unmap_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr && pready)
        else $error("no error answer for unmapped address");
    chk_unmap_zero: assert property (psel && penable && !pwrite && paddr > 8'h14
        |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    chk_map_ok: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("error on mapped address");
    chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
endmodule
bind mies_core mies_checker mies_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout), .osc_stop(osc_stop));

// ===== verification/tb_top.sv
/* Self-checking bench for mies_core over APB.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
module tb_top;
    import mies_pkg::*;
    // ==========================================================
    // Stimulus, design and counters
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic wdt_timeout = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_stop;
    logic [31:0] rd_data;
    logic err_seen;
    logic [8:0] ref9;
    logic [7:0] mv;
    logic [31:0] wd_held;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] daa_in [6] = '{8'h9A, 8'h45, 8'h12, 8'h30, 8'h99, 8'hA0};
    logic [1:0] daa_fl [6] = '{2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b00};
    mies_core mies_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_timeout(wdt_timeout), .osc_stop(osc_stop));
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            error_cnt++;
            close_out();
        end
    end
    // ==========================================================
    // Tasks; each transfer starts on a fresh edge so no signal is driven twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd_data = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic op(input mies_op_t o);
        wr(MIES_REG_CMD, {28'h000_0000, o});
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_data, exp);
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Nibble-wise decimal correction, low carry feeds the high nibble
    function automatic logic [8:0] daa_ref(input logic [7:0] a, input logic ac, input logic c);
        logic nc;
        logic [4:0] lo;
        logic [4:0] hi;
        nc = a[3:0] > 4'h9;
        lo = (nc || ac) ? {1'b0, a[3:0]} + 5'h06 : {1'b0, a[3:0]};
        hi = {1'b0, a[7:4]} + {4'h0, nc};
        c = c || hi > 5'h09;
        if (c) hi = hi + 5'h06;
        return {c, hi[3:0], lo[3:0]};
    endfunction
    // ==========================================================
    // Tests
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 4; a <= 16; a += 4)
            rd_chk(a[7:0], 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(rd_data, 32'h0000_0000);
        chk({31'h0, err_seen}, 32'h0000_0001);
        $display("reset and unmapped test done");
        wr(MIES_REG_FLAGS, 32'h0000_000F);
        wr(MIES_REG_MEM, 32'h0000_005A);
        op(MIES_OP_CPL_ACC);
        rd_chk(MIES_REG_ACC, 32'h0000_00A5);
        rd_chk(MIES_REG_MEM, 32'h0000_005A);
        wr(MIES_REG_MEM, 32'h0000_0000);
        op(MIES_OP_DEC_ACC);
        rd_chk(MIES_REG_ACC, 32'h0000_00FF);
        rd_chk(MIES_REG_MEM, 32'h0000_0000);
        rd_chk(MIES_REG_FLAGS, 32'h0000_000F);
        $display("complement and decrement test done");
        for (int i = 0; i < 6; i++)
        begin
            ref9 = daa_ref(daa_in[i], daa_fl[i][1], daa_fl[i][0]);
            wr(MIES_REG_ACC, {24'h00_0000, daa_in[i]});
            wr(MIES_REG_FLAGS, {28'h000_0000, 2'b11, daa_fl[i]});
            op(MIES_OP_DEC_ADJUST);
            rd_chk(MIES_REG_MEM, {24'h00_0000, ref9[7:0]});
            rd_chk(MIES_REG_FLAGS, {28'h000_0000, 2'b11, daa_fl[i][1], ref9[8]});
        end
        $display("decimal adjust test done");
        for (int i = 0; i < 4; i++)
        begin
            mv = i[1] ? 8'h42 : 8'h81;
            ref9 = i[0] ? {mv[0], i[0] ^ i[1], mv[7:1]} : {mv[7], mv[6:0], i[0] ^ i[1]};
            wr(MIES_REG_MEM, {24'h00_0000, mv});
            wr(MIES_REG_ACC, 32'h0000_003C);
            wr(MIES_REG_FLAGS, {31'h0, i[0] ^ i[1]});
            op(mies_op_t'(4'h6 + i[3:0]));
            rd_chk(i[1] ? MIES_REG_ACC : MIES_REG_MEM, {24'h00_0000, ref9[7:0]});
            rd_chk(i[1] ? MIES_REG_MEM : MIES_REG_ACC, {24'h00_0000, i[1] ? mv : 8'h3C});
            rd_chk(MIES_REG_FLAGS, {31'h0, ref9[8]});
        end
        $display("rotate test done");
        // OR, move, jump and return ops, with the zero flag from OR only
        wr(MIES_REG_FLAGS, 32'h0000_0000);
        wr(MIES_REG_ACC, 32'h0000_0005);
        wr(MIES_REG_MEM, 32'h0000_0030);
        op(MIES_OP_OR_A_M);
        rd_chk(MIES_REG_ACC, 32'h0000_0035);
        wr(MIES_REG_MEM, 32'h0000_00C0);
        op(MIES_OP_ORM);
        rd_chk(MIES_REG_MEM, 32'h0000_00F5);
        wr(MIES_REG_ACC, 32'h0000_0000);
        op(MIES_OP_MOV_M_A);
        rd_chk(MIES_REG_MEM, 32'h0000_0000);
        op(MIES_OP_OR_A_M);
        rd_chk(MIES_REG_FLAGS, 32'h0000_0004);
        wr(MIES_REG_MEM, 32'h0000_005C);
        op(MIES_OP_MOV_A_M);
        rd_chk(MIES_REG_ACC, 32'h0000_005C);
        wr(MIES_REG_CMD, {16'h0000, 12'h123, MIES_OP_JMP});
        rd_chk(MIES_REG_PC, 32'h0000_0123);
        wr(MIES_REG_PC, 32'h0000_0456);
        op(MIES_OP_RET);
        rd_chk(MIES_REG_PC, 32'h0000_0456);
        op(MIES_OP_NONE);
        rd_chk(MIES_REG_PC, 32'h0000_0457);
        $display("logic, move and jump test done");
        wr(MIES_REG_FLAGS, 32'h0000_0001);
        wdt_timeout <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_chk(MIES_REG_FLAGS, 32'h0000_0021);
        op(MIES_OP_HALT);
        @(negedge sys_clk);
        chk({31'h0, osc_stop}, 32'h0000_0001);
        rd_chk(MIES_REG_FLAGS, 32'h0000_0011);
        // Stopped oscillator freezes the watchdog count across reads
        apb(1'b0, MIES_REG_WDT, 32'h0000_0000);
        wd_held = rd_data;
        rd_chk(MIES_REG_WDT, wd_held);
        op(MIES_OP_WDT_CLEAR);
        @(negedge sys_clk);
        chk({31'h0, osc_stop}, 32'h0000_0000);
        rd_chk(MIES_REG_FLAGS, 32'h0000_0001);
        // Count restarts from zero; the read setup is sampled five edges after the clear
        rd_chk(MIES_REG_WDT, 32'h0000_0004);
        $display("halt and watchdog clear test done");
        close_out();
    end
endmodule
